// ===== acl_action_combine_stats.sv
// Combines two ACL lookup actions and keeps lookup sticky flags and match counters.
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps

// Function
// - Outer-point actions first, then inner, first-before-second.
// - Later action overrides; sticky fields never undone.
// - Later policer index used only if enabled.
// - Later log interval wins only when nonzero.
// - Mask modes 3, 4, 6 are sticky.
// - Later mask applied on earlier; skipped if sticky.
// - Later mirror probe wins only when nonzero.
// - Rewrite functions: union, later wins on overlap.
// - Hop preset, routing mode, MAC: later wins overlap.
// - Later transport replace wins only when enabled.
// - Match identifier masked per action, chained.
// - Each applied action increments its own counter.
// - Later timing domain wins only when nonzero.
// - Each lookup sets its key-type sticky flag.
// - Write one clears that sticky flag only.
// - Every returned action increments one of 4096 counters.
// - Shared counter index increments once per action.
// - Counters writable by software; zero clears.
// - First-lookup discard: ingress optional, never egress.
// - Second-lookup discard alone: ingress always, egress optional; if both discard, the first-lookup rule applies.
// - Rewrites are carried into mirror copies.
module acl_action_combine_stats (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Lookup results and frame state
  input acl_combine_pkg::lookup_s lookup_i,
  // Combined decision
  output acl_combine_pkg::result_s result_o,
  output logic result_valid_o,
  output logic mirror_rewritten_o,
  output logic igr_leg_count_o,
  output logic egr_leg_count_o,
  // Wishbone slave
  input acl_combine_pkg::wb_req_s wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o
);
  import acl_combine_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ctrl;
    logic [31:0] sticky;
    logic [CNT_NUM-1:0][CNT_W-1:0] cnt;
    logic ack;
    logic [31:0] rdata;
    result_s res;
    logic res_valid;
    logic mirror_rw;
    logic igr_cnt;
    logic egr_cnt;
  } state_s;

  localparam state_s STATE_RST = '{
    ctrl: CTRL_RST,
    sticky: STICKY_RST,
    cnt: {CNT_NUM{CNT_RST}},
    ack: 1'b0,
    rdata: 32'h0,
    res: '0,
    res_valid: 1'b0,
    mirror_rw: 1'b0,
    igr_cnt: 1'b0,
    egr_cnt: 1'b0
  };

  state_s q;
  state_s d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic mode_sticky(input logic [2:0] m);
    mode_sticky = (m == MM_REPLACE_ALL) || (m == MM_REDIRECT_GROUP) || (m == MM_STACK_FORWARD);
  endfunction : mode_sticky

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // Folds one action onto the running result; called for earlier then later action.
  function automatic result_s apply_action(input result_s r, input logic mstk, input action_s a);
    result_s o;
    result_s f;
    o = r;
    f = a.fields;
    // Sticky flags only ever get set.
    o.hit_me_once = r.hit_me_once | f.hit_me_once;
    o.intr_ena = r.intr_ena | f.intr_ena;
    o.learn_disable = r.learn_disable | f.learn_disable;
    o.route_disable = r.route_disable | f.route_disable;
    o.swap_mac_enable = r.swap_mac_enable | f.swap_mac_enable;
    o.discard = r.discard | f.discard;
    o.cpu_copy_ena = r.cpu_copy_ena | f.cpu_copy_ena;
    if (!r.cpu_copy_ena && f.cpu_copy_ena) begin
      o.cpu_queue = f.cpu_queue;
    end
    if (f.policer_enable) begin
      o.policer_enable = 1'b1;
      o.policer_index = f.policer_index;
    end
    if (f.log_message_interval != 4'h0) begin
      o.log_message_interval = f.log_message_interval;
    end
    if (!mstk) begin
      case (f.mask_mode)
        MM_AND: o.port_mask = r.port_mask & f.port_mask;
        MM_OR: o.port_mask = r.port_mask | f.port_mask;
        MM_REPLACE_ALL, MM_REDIRECT_GROUP, MM_REPLACE, MM_STACK_FORWARD: o.port_mask = f.port_mask;
        default: o.port_mask = r.port_mask;
      endcase
      if (f.mask_mode != MM_NONE) begin
        o.mask_mode = f.mask_mode;
      end
    end
    if (f.mirror_probe != 2'h0) begin
      o.mirror_probe = f.mirror_probe;
    end
    // Each bit is one rewrite function, so the union keeps every triggered one.
    o.rewrite_command = r.rewrite_command | f.rewrite_command;
    o.hop_limit_preset_enable = r.hop_limit_preset_enable | f.hop_limit_preset_enable;
    if (f.acl_routing_rewrite_mode != 4'h0) begin
      o.acl_routing_rewrite_mode = f.acl_routing_rewrite_mode;
      o.value_a = f.value_a;
    end
    if (f.transport_port_replace_enable) begin
      o.transport_port_replace_enable = 1'b1;
    end
    o.match_identifier = (r.match_identifier & ~a.match_identifier_mask)
                       | (f.match_identifier & a.match_identifier_mask);
    if (f.timing_domain_select != 2'h0) begin
      o.timing_domain_select = f.timing_domain_select;
    end
    apply_action = o;
  endfunction : apply_action

  // ----------------------------------------------------------------
  // Action ordering
  // ----------------------------------------------------------------
  logic swap_order;
  logic early_valid;
  logic late_valid;
  action_s early_act;
  action_s late_act;
  result_s base_res;
  result_s mid_res;
  result_s fin_res;
  logic mid_sticky;

  always_comb begin
    // Only an inner first with an outer second reverses the order.
    swap_order = lookup_i.first_valid && lookup_i.second_valid
               && lookup_i.first.inner_point_flag && !lookup_i.second.inner_point_flag;
    if (swap_order) begin
      early_act = lookup_i.second;
      late_act = lookup_i.first;
      early_valid = lookup_i.second_valid;
      late_valid = lookup_i.first_valid;
    end else begin
      early_act = lookup_i.first;
      late_act = lookup_i.second;
      early_valid = lookup_i.first_valid;
      late_valid = lookup_i.second_valid;
    end
  end

  // ----------------------------------------------------------------
  // Merge
  // ----------------------------------------------------------------
  always_comb begin
    base_res = '0;
    base_res.port_mask = lookup_i.port_mask;
    base_res.match_identifier = lookup_i.match_identifier;
    mid_res = early_valid ? apply_action(base_res, 1'b0, early_act) : base_res;
    mid_sticky = early_valid && mode_sticky(early_act.fields.mask_mode);
    fin_res = late_valid ? apply_action(mid_res, mid_sticky, late_act) : mid_res;
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic bus_req;
  logic bus_wr;
  logic hit_ctrl;
  logic hit_sticky;
  logic hit_cnt;
  logic [IDX_W-1:0] cnt_sel;
  logic [31:0] wmask;
  logic [31:0] rd_val;

  always_comb begin
    bus_req = wb_i.cyc && wb_i.stb;
    // A write takes effect on the edge that sees the acknowledge.
    bus_wr = bus_req && wb_i.we && q.ack;
    hit_ctrl = wb_i.adr[ADR_W-1:2] == CTRL_OFS[ADR_W-1:2];
    hit_sticky = wb_i.adr[ADR_W-1:2] == STICKY_OFS[ADR_W-1:2];
    hit_cnt = wb_i.adr[CNT_REGION_BIT];
    cnt_sel = wb_i.adr[CNT_REGION_BIT-1:2];
    wmask = lane_mask(wb_i.sel);
    if (hit_cnt) begin
      rd_val = q.cnt[cnt_sel];
    end else if (hit_ctrl) begin
      rd_val = {30'h0, q.ctrl};
    end else if (hit_sticky) begin
      rd_val = q.sticky;
    end else begin
      rd_val = 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [31:0] sticky_set;
  logic [31:0] sticky_clr;
  logic first_drop;
  logic second_drop;

  always_comb begin
    d = q;
    // Bus handshake: answer one cycle after the request, drop the cycle after.
    d.ack = bus_req && !q.ack;
    if (bus_req && !q.ack) begin
      d.rdata = rd_val;
    end
    if (bus_wr && hit_ctrl) begin
      d.ctrl = (q.ctrl & ~wmask[1:0]) | (wb_i.dat[1:0] & wmask[1:0]);
    end
    // Sticky key-type flags; a new set beats a clear in the same cycle.
    sticky_set = 32'h0;
    if (lookup_i.valid && lookup_i.first_valid) begin
      sticky_set[lookup_i.first_key] = 1'b1;
    end
    if (lookup_i.valid && lookup_i.second_valid) begin
      sticky_set[STICKY_LOOKUP1_POS + int'(lookup_i.second_key)] = 1'b1;
    end
    sticky_clr = (bus_wr && hit_sticky) ? (wb_i.dat & wmask) : 32'h0;
    d.sticky = (q.sticky & ~sticky_clr) | sticky_set;
    // Match counters; two actions on one index add two.
    if (lookup_i.valid && lookup_i.first_valid) begin
      d.cnt[lookup_i.first.counter_index] = q.cnt[lookup_i.first.counter_index] + 32'h1;
    end
    if (lookup_i.valid && lookup_i.second_valid) begin
      d.cnt[lookup_i.second.counter_index] = d.cnt[lookup_i.second.counter_index] + 32'h1;
    end
    if (bus_wr && hit_cnt) begin
      d.cnt[cnt_sel] = (q.cnt[cnt_sel] & ~wmask) | (wb_i.dat & wmask);
    end
    // Combined result toward forwarding and mirroring.
    d.res_valid = lookup_i.valid;
    if (lookup_i.valid) begin
      d.res = fin_res;
    end
    d.mirror_rw = lookup_i.valid && (fin_res.mirror_probe != 2'h0)
               && ((fin_res.rewrite_command != 11'h0) || (fin_res.acl_routing_rewrite_mode != 4'h0)
               || fin_res.swap_mac_enable || fin_res.transport_port_replace_enable);
    // Router-leg statistics for routed frames dropped by a rule.
    first_drop = lookup_i.first_valid && lookup_i.first.fields.discard;
    second_drop = lookup_i.second_valid && lookup_i.second.fields.discard;
    d.igr_cnt = 1'b0;
    d.egr_cnt = 1'b0;
    if (lookup_i.valid && lookup_i.routed) begin
      if (first_drop) begin
        d.igr_cnt = q.ctrl[CTRL_IGR_BIT];
      end else if (second_drop) begin
        d.igr_cnt = 1'b1;
        d.egr_cnt = q.ctrl[CTRL_EGR_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      q <= STATE_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign result_o = q.res;
  assign result_valid_o = q.res_valid;
  assign mirror_rewritten_o = q.mirror_rw;
  assign igr_leg_count_o = q.igr_cnt;
  assign egr_leg_count_o = q.egr_cnt;
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;

endmodule : acl_action_combine_stats

// ===== acl_action_combine_stats_tb.sv
// Self-checking bench for the ACL action combiner.
`timescale 1ns/100ps
module acl_action_combine_stats_tb;
  import acl_combine_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1;
  logic rv, mir, igr, egr, ack;
  logic [31:0] rd, q;
  lookup_s lk, f;
  wb_req_s wb = '0;
  result_s res;
  int n_fail = 0, total_checks = 0;
  acl_action_combine_stats DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .lookup_i(lk), .result_o(res),
    .result_valid_o(rv), .mirror_rewritten_o(mir), .igr_leg_count_o(igr), .egr_leg_count_o(egr),
    .wb_i(wb), .wb_ack_o(ack), .wb_dat_o(rd));
  acl_lookup_model ENG (.clk_i(clk_i), .lookup_o(lk));
  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task automatic bus(input logic we, input logic [14:0] adr, input logic [31:0] d);
    wb <= '{1'b1, 1'b1, we, adr, 4'hF, d};
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    check(ack, 1'b1);
    q = rd;
    wb <= '0;
    @(posedge clk_i);
  endtask : bus
  function automatic lookup_s both();
    return '{valid: 1'b1, first_valid: 1'b1, second_valid: 1'b1, port_mask: 32'h00F0, default: '0};
  endfunction : both
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_stat();
    bus(1'b1, 15'h0100, 32'hFFFF_FFFF);
    bus(1'b0, CTRL_OFS, 32'h0);
    check(q, CTRL_RST);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, CTRL_OFS, 32'(c));
      for (int d = 0; d < 2; d++) begin
        f = both();
        f.routed = 1'b1;
        f.first.fields.discard = (d == 0);
        f.second.fields.discard = (d == 1);
        ENG.send(f);
        check(igr, d ? 1'b1 : c[0]);
        check(egr, d ? c[1] : 1'b0);
      end
    end
  endtask : t_stat
  task automatic t_mask();
    logic [2:0] m [5] = '{MM_REPLACE_ALL, MM_REDIRECT_GROUP, MM_STACK_FORWARD, MM_REPLACE, MM_REPLACE};
    logic [31:0] ex [5] = '{32'h0C00, 32'h0C00, 32'h0C00, 32'h0C33, 32'h0C00};
    for (int i = 0; i < 5; i++) begin
      f = both();
      f.first.inner_point_flag = (i == 4);
      f.first.fields.mask_mode = m[i];
      f.first.fields.port_mask = 32'h0C00;
      f.second.fields.mask_mode = (i == 4) ? MM_AND : MM_OR;
      f.second.fields.port_mask = 32'h0033;
      ENG.send(f);
      check(res.port_mask, ex[i]);
    end
  endtask : t_mask
  task automatic t_act();
    f = both();
    f.match_identifier = 16'hAAAA;
    f.first.match_identifier_mask = 16'h00FF;
    f.second.match_identifier_mask = 16'h0FF0;
    f.first.fields = '{policer_enable: 1'b1, policer_index: 7'h11, log_message_interval: 4'h5,
      rewrite_command: 11'h001, timing_domain_select: 2'h2, match_identifier: 16'h1234,
      transport_port_replace_enable: 1'b1, acl_routing_rewrite_mode: 4'h1, value_a: 48'h1111, default: '0};
    f.second.fields = '{policer_enable: 1'b1, policer_index: 7'h22, log_message_interval: 4'h9, mirror_probe: 2'h2,
      rewrite_command: 11'h004, hop_limit_preset_enable: 1'b1, match_identifier: 16'h5678,
      acl_routing_rewrite_mode: 4'h2, value_a: 48'h2222, default: '0};
    ENG.send(f);
    check(res.policer_index, 7'h22);
    check(res.log_message_interval, 4'h9);
    check(res.mirror_probe, 2'h2);
    check(res.timing_domain_select, 2'h2);
    check(res.rewrite_command, 11'h005);
    check(res.hop_limit_preset_enable, 1'b1);
    check(res.match_identifier, 16'hA674);
    check(mir, 1'b1);
    check(rv, 1'b1);
    check(res.transport_port_replace_enable, 1'b1);
    check(res.acl_routing_rewrite_mode, 4'h2);
    check(res.value_a, 48'h2222);
  endtask : t_act
  task automatic t_cnt();
    bus(1'b0, 15'h7FFC, 32'h0);
    check(q, CNT_RST);
    bus(1'b1, 15'h4014, 32'h0100);
    bus(1'b1, STICKY_OFS, 32'hFFFF_FFFF);
    f = both();
    f.first_key = 4'h3;
    f.second_key = 4'h9;
    f.first.counter_index = 12'h005;
    f.second.counter_index = 12'h005;
    ENG.send(f);
    f.second.counter_index = 12'hFFF;
    ENG.send(f);
    bus(1'b0, 15'h4014, 32'h0);
    check(q, 32'h0103);
    bus(1'b0, 15'h7FFC, 32'h0);
    check(q, 32'h0001);
    bus(1'b0, STICKY_OFS, 32'h0);
    check(q, 32'h0200_0008);
    bus(1'b1, STICKY_OFS, 32'h0008);
    bus(1'b0, STICKY_OFS, 32'h0);
    check(q, 32'h0200_0000);
    bus(1'b1, 15'h4014, 32'h0);
    bus(1'b0, 15'h4014, 32'h0);
    check(q, 32'h0);
  endtask : t_cnt
  task automatic t_edge();
    lookup_s g;
    g = both();
    g.first.counter_index = 12'h006;
    g.second.counter_index = 12'h006;
    // The bus write and both increments land on the same edge.
    fork
      bus(1'b1, 15'h4018, 32'h0055);
      ENG.send(g);
    join
    bus(1'b0, 15'h4018, 32'h0);
    check(q, 32'h0055);
    // With the enable low a frame must leave no trace.
    ce_i <= 1'b0;
    g.first.counter_index = 12'h007;
    g.second.counter_index = 12'h007;
    ENG.send(g);
    check(rv, 1'b0);
    ce_i <= 1'b1;
    bus(1'b0, 15'h401C, 32'h0);
    check(q, 32'h0);
  endtask : t_edge
  initial begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_stat();
    t_mask();
    t_act();
    t_cnt();
    t_edge();
    end_sim();
  end
endmodule : acl_action_combine_stats_tb
bind acl_action_combine_stats acl_combine_chk CHK (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .lookup_i(lookup_i), .result_o(result_o), .result_valid_o(result_valid_o), .mirror_rewritten_o(mirror_rewritten_o),
  .igr_leg_count_o(igr_leg_count_o), .egr_leg_count_o(egr_leg_count_o));

// ===== acl_combine_chk.sv
// Port assertions for the ACL action combiner.
`timescale 1ns/100ps
module acl_combine_chk (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Frames and decisions
  input acl_combine_pkg::lookup_s lookup_i,
  input acl_combine_pkg::result_s result_o,
  input wire logic result_valid_o,
  input wire logic mirror_rewritten_o,
  input wire logic igr_leg_count_o,
  input wire logic egr_leg_count_o
);
  import acl_combine_pkg::*;
  logic swp;
  logic fd, sd;
  action_s ea;
  action_s la;
  // The earlier action is the second only when it sits at the outer point and the first does not.
  assign swp = lookup_i.first.inner_point_flag && !lookup_i.second.inner_point_flag;
  assign ea = swp ? lookup_i.second : lookup_i.first;
  assign la = swp ? lookup_i.first : lookup_i.second;
  assign fd = lookup_i.first_valid && lookup_i.first.fields.discard;
  assign sd = lookup_i.second_valid && lookup_i.second.fields.discard;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_both;
    ce_i && lookup_i.valid && lookup_i.first_valid && lookup_i.second_valid;
  endsequence
  a_policer_later: assert property (s_both ##0 la.fields.policer_enable |=>
    result_o.policer_index == $past(la.fields.policer_index)) else $error("policer index wrong");
  a_log_later: assert property (s_both ##0 (la.fields.log_message_interval != 4'h0) |=>
    result_o.log_message_interval == $past(la.fields.log_message_interval)) else $error("log interval wrong");
  a_mask_sticky: assert property (s_both ##0 (ea.fields.mask_mode inside {3'h3, 3'h4, 3'h6}) |=>
    result_o.port_mask == $past(ea.fields.port_mask)) else $error("sticky mask undone");
  a_probe_later: assert property (s_both ##0 (la.fields.mirror_probe != 2'h0) |=>
    result_o.mirror_probe == $past(la.fields.mirror_probe)) else $error("mirror probe wrong");
  a_discard_kept: assert property (s_both ##0 ea.fields.discard |=> result_o.discard)
    else $error("discard undone");
  a_egress_first: assert property (ce_i && lookup_i.valid && lookup_i.routed && fd |=> !egr_leg_count_o)
    else $error("egress counted");
  a_ingress_second: assert property (ce_i && lookup_i.valid && lookup_i.routed && !fd && sd |=> igr_leg_count_o)
    else $error("ingress missed");
  a_mirror_cause: assert property (mirror_rewritten_o |-> result_valid_o && result_o.mirror_probe != 2'h0)
    else $error("mirror flag without probe");
endmodule : acl_combine_chk

// ===== acl_combine_pkg.sv
// Shared constants and carrier types for the ACL action combiner and its statistics.
package acl_combine_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CNT_NUM = 4096;
  localparam int CNT_W = 32;
  localparam int IDX_W = 12;
  localparam int PMASK_W = 32;
  localparam int KEY_TYPES = 16;
  localparam int KEY_W = 4;
  localparam int ADR_W = 15;

  // ----------------------------------------------------------------
  // Register map and field positions
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] CTRL_OFS = 15'h0000;
  localparam logic [ADR_W-1:0] STICKY_OFS = 15'h0004;
  localparam int CNT_REGION_BIT = 14;
  localparam int CTRL_IGR_BIT = 0;
  localparam int CTRL_EGR_BIT = 1;
  localparam int STICKY_LOOKUP1_POS = 16;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [31:0] STICKY_RST = 32'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0;

  // ----------------------------------------------------------------
  // Port-mask modes
  // ----------------------------------------------------------------
  localparam logic [2:0] MM_NONE = 3'h0;
  localparam logic [2:0] MM_AND = 3'h1;
  localparam logic [2:0] MM_OR = 3'h2;
  localparam logic [2:0] MM_REPLACE_ALL = 3'h3;
  localparam logic [2:0] MM_REDIRECT_GROUP = 3'h4;
  localparam logic [2:0] MM_REPLACE = 3'h5;
  localparam logic [2:0] MM_STACK_FORWARD = 3'h6;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hit_me_once;
    logic intr_ena;
    logic cpu_copy_ena;
    logic [2:0] cpu_queue;
    logic learn_disable;
    logic route_disable;
    logic swap_mac_enable;
    logic discard;
    logic policer_enable;
    logic [6:0] policer_index;
    logic [3:0] log_message_interval;
    logic [2:0] mask_mode;
    logic [PMASK_W-1:0] port_mask;
    logic [1:0] mirror_probe;
    logic [10:0] rewrite_command;
    logic hop_limit_preset_enable;
    logic transport_port_replace_enable;
    logic [15:0] match_identifier;
    logic [3:0] acl_routing_rewrite_mode;
    logic [47:0] value_a;
    logic [1:0] timing_domain_select;
  } result_s;

  typedef struct packed {
    logic inner_point_flag;
    logic [15:0] match_identifier_mask;
    logic [IDX_W-1:0] counter_index;
    result_s fields;
  } action_s;

  typedef struct packed {
    logic valid;
    logic routed;
    logic [PMASK_W-1:0] port_mask;
    logic [15:0] match_identifier;
    logic first_valid;
    logic [KEY_W-1:0] first_key;
    action_s first;
    logic second_valid;
    logic [KEY_W-1:0] second_key;
    action_s second;
  } lookup_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

endpackage : acl_combine_pkg

// ===== acl_lookup_model.sv
// Behavioural lookup engine that hands frames to the combiner.
`timescale 1ns/100ps
module acl_lookup_model (
  // Clock
  input wire logic clk_i,
  // Frame towards the combiner
  output acl_combine_pkg::lookup_s lookup_o
);
  import acl_combine_pkg::*;
  initial lookup_o = '0;
  // After its one cycle the frame turns to junk, so stale fields never pass for live ones.
  task automatic send(input lookup_s f);
    lookup_s idle;
    idle = ~f;
    idle.valid = 1'b0;
    @(posedge clk_i);
    lookup_o <= f;
    @(posedge clk_i);
    lookup_o <= idle;
    @(posedge clk_i);
  endtask : send
endmodule : acl_lookup_model
